/* design/adc_seq_pkg.sv */
// constants and types shared by the conversion sequencer
package adc_seq_pkg;
    localparam int CLK_MHZ = 200;
    localparam int CH_W = 5;
    localparam logic [4:0] CH_ALL_ONES = 5'h1f;
    localparam int RES_W = 12;
    localparam int FIFO_DEP_W = 3;
    localparam logic [2:0] FIFO_DEP_OFF = 3'h0;
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    // half-cycle units: 3.5 and 23.5 clocks
    localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
    localparam logic [5:0] SAMPLE_LONG_HALF = 6'h2f;
    // successive approximation length after sampling, in conversion clocks
    localparam logic [5:0] SAR_8 = 6'h0d;
    localparam logic [5:0] SAR_10_12 = 6'h10;
    localparam logic [5:0] FIRST_EXTRA = 6'h03;
    localparam logic [2:0] BUS_FINISH = 3'h5;
    localparam int ASYNC_STARTUP_NS = 5000;
    localparam int ASYNC_STARTUP_CYC = ASYNC_STARTUP_NS * CLK_MHZ / 1000;
    typedef enum logic [2:0] {
        ST_IDLE, ST_STARTUP, ST_SAMPLE, ST_SAR, ST_FINISH
    } seq_state_t;
endpackage

/* design/adc_trig_sync.sv */
// trigger synchroniser with rising edge detector
`timescale 1ns/1ps
`default_nettype none
module adc_trig_sync (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic trig_in,
    output logic trig_rise
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    // first stage only feeds the second stage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= trig_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end
    assign trig_rise = sync_ff & ~prev_ff;
endmodule
`default_nettype wire

/* design/adc_clk_div.sv */
// conversion clock tick generator: source select and divider
`timescale 1ns/1ps
`default_nettype none
module adc_clk_div (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] input_clock_select,
    input wire logic [1:0] clock_divide_select,
    input wire logic alt_tick,
    input wire logic async_tick,
    output logic conv_tick
);
    logic half_ff;
    logic src_tick;
    logic [2:0] cnt_ff;
    logic [2:0] lim;
    // sources become one-cycle ticks on mclk; alt and async ticks are synchronous pulses
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            half_ff <= 1'b0;
        end else begin
            half_ff <= run ? ~half_ff : 1'b0;
        end
    end
    always_comb begin
        case (input_clock_select)
            adc_seq_pkg::CLK_BUS: src_tick = 1'b1;
            adc_seq_pkg::CLK_BUS_HALF: src_tick = half_ff;
            adc_seq_pkg::CLK_ALT: src_tick = alt_tick;
            default: src_tick = async_tick;
        endcase
    end
    assign lim = 3'((1 << clock_divide_select) - 1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 3'h0;
        end else if (!run) begin
            cnt_ff <= 3'h0;
        end else if (src_tick) begin
            cnt_ff <= (cnt_ff >= lim) ? 3'h0 : 3'(cnt_ff + 3'h1);
        end
    end
    assign conv_tick = run & src_tick & (cnt_ff >= lim);
endmodule
`default_nettype wire

/* design/adc_conversion_sequencer.sv */
// conversion sequencer of a successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer #(
    parameter int STARTUP_CYC = adc_seq_pkg::ASYNC_STARTUP_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    // ==========================================
    // control fields and register write strobes
    input wire logic status_control_one_wr,
    input wire logic [4:0] input_channel_select,
    input wire logic done_irq_enable,
    input wire logic continuous_convert_enable,
    input wire logic hw_trigger_select,
    input wire logic other_ctrl_wr,
    input wire logic compare_enable,
    input wire logic [1:0] mode_select,
    input wire logic long_sample_select,
    input wire logic [1:0] input_clock_select,
    input wire logic [1:0] clock_divide_select,
    input wire logic [2:0] fifo_depth_field,
    input wire logic fifo_filled,
    input wire logic stop_enter,
    input wire logic result_high_rd,
    input wire logic result_low_rd,
    input wire logic done_flag_clear,
    // ==========================================
    // analog core and trigger side
    input wire logic hw_conv_trigger,
    input wire logic alt_tick,
    input wire logic async_tick,
    input wire logic [11:0] core_result,
    input wire logic compare_true,
    output logic converter_enable,
    output logic sample_active,
    output logic async_conv_clock_en,
    output logic fifo_advance,
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte,
    output logic conversion_done_flag,
    output logic done_irq,
    output logic conv_active
);
    logic trig_rise;
    logic conv_tick;
    logic run;
    adc_seq_pkg::seq_state_t state_ff;
    logic [5:0] cnt_ff;
    logic [2:0] bus_cnt_ff;
    logic [15:0] start_cnt_ff;
    logic first_ff;
    logic hw_seq_ff;
    logic hi_read_ff;
    logic [7:0] res_h_ff;
    logic [7:0] res_l_ff;
    logic done_ff;
    logic fifo_mode;
    logic chan_valid;
    logic abort_all;
    logic sw_start;
    logic hw_start;
    logic start;
    logic finish;
    logic blocked;
    logic keep_going;
    logic [5:0] sample_len;
    logic [5:0] sar_len;
    logic hi_res;

    adc_trig_sync u_trig (
        .mclk(mclk),
        .rst_n(rst_n),
        .trig_in(hw_conv_trigger),
        .trig_rise(trig_rise)
    );
    adc_clk_div u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(run),
        .input_clock_select(input_clock_select),
        .clock_divide_select(clock_divide_select),
        .alt_tick(alt_tick),
        .async_tick(async_tick),
        .conv_tick(conv_tick)
    );

    // ==========================================
    // start and abort decode
    assign fifo_mode = fifo_depth_field != adc_seq_pkg::FIFO_DEP_OFF;
    assign chan_valid = input_channel_select != adc_seq_pkg::CH_ALL_ONES;
    assign conv_active = state_ff != adc_seq_pkg::ST_IDLE;
    assign run = conv_active;
    assign abort_all = other_ctrl_wr | (stop_enter & (input_clock_select != adc_seq_pkg::CLK_ASYNC))
        | (status_control_one_wr & fifo_mode);
    // sw start: direct write with depth zero, or fifo filled to depth
    assign sw_start = !hw_trigger_select & chan_valid & (fifo_mode ? fifo_filled
        : status_control_one_wr);
    // edges during a conversion or a running hw continuous sequence are dropped
    assign hw_start = hw_trigger_select & trig_rise & chan_valid & !conv_active
        & !hw_seq_ff & (!fifo_mode | fifo_filled);
    assign start = !abort_all & (sw_start | hw_start);
    assign hi_res = mode_select != adc_seq_pkg::MODE_8;
    assign sample_len = long_sample_select ? adc_seq_pkg::SAMPLE_LONG_HALF
        : adc_seq_pkg::SAMPLE_SHORT_HALF;
    assign sar_len = 6'((hi_res ? adc_seq_pkg::SAR_10_12 : adc_seq_pkg::SAR_8)
        + (first_ff ? adc_seq_pkg::FIRST_EXTRA : 6'h00));
    assign finish = (state_ff == adc_seq_pkg::ST_FINISH) && (bus_cnt_ff == 3'h1);
    assign blocked = hi_res & hi_read_ff;
    // single compare-false with blocking: stop; other blocked cases relaunch
    assign keep_going = blocked ? !(compare_enable & !compare_true & !continuous_convert_enable)
        : continuous_convert_enable;

    // ==========================================
    // sequencer; cnt_ff counts half conversion clocks during sampling
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= adc_seq_pkg::ST_IDLE;
            cnt_ff <= 6'h00;
            bus_cnt_ff <= 3'h0;
            start_cnt_ff <= 16'h0000;
            first_ff <= 1'b1;
        end else if (abort_all || (status_control_one_wr && !start) || !chan_valid) begin
            state_ff <= adc_seq_pkg::ST_IDLE;
            first_ff <= 1'b1;
        end else if (start && (!conv_active || status_control_one_wr)) begin
            first_ff <= 1'b1;
            cnt_ff <= 6'h00;
            start_cnt_ff <= 16'(STARTUP_CYC);
            state_ff <= (input_clock_select == adc_seq_pkg::CLK_ASYNC)
                ? adc_seq_pkg::ST_STARTUP : adc_seq_pkg::ST_SAMPLE;
        end else begin
            case (state_ff)
                adc_seq_pkg::ST_IDLE: begin
                    cnt_ff <= 6'h00;
                end
                adc_seq_pkg::ST_STARTUP: begin
                    if (start_cnt_ff <= 16'h0001) begin
                        state_ff <= adc_seq_pkg::ST_SAMPLE;
                    end
                    start_cnt_ff <= 16'(start_cnt_ff - 16'h0001);
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    // two half clocks per tick; 3.5 rounds up to 4 ticks
                    if (conv_tick) begin
                        if (6'(cnt_ff + 6'h02) >= sample_len) begin
                            state_ff <= adc_seq_pkg::ST_SAR;
                            cnt_ff <= 6'h00;
                        end else begin
                            cnt_ff <= 6'(cnt_ff + 6'h02);
                        end
                    end
                end
                adc_seq_pkg::ST_SAR: begin
                    if (conv_tick) begin
                        if (6'(cnt_ff + 6'h01) >= 6'(sar_len - 6'h04)) begin
                            state_ff <= adc_seq_pkg::ST_FINISH;
                            bus_cnt_ff <= adc_seq_pkg::BUS_FINISH;
                            cnt_ff <= 6'h00;
                        end else begin
                            cnt_ff <= 6'(cnt_ff + 6'h01);
                        end
                    end
                end
                adc_seq_pkg::ST_FINISH: begin
                    bus_cnt_ff <= 3'(bus_cnt_ff - 3'h1);
                    if (finish) begin
                        first_ff <= 1'b0;
                        state_ff <= keep_going ? adc_seq_pkg::ST_SAMPLE
                            : adc_seq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= adc_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // hw continuous sequence marker
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hw_seq_ff <= 1'b0;
        end else if (!conv_active && !start) begin
            hw_seq_ff <= 1'b0;
        end else if (hw_start && continuous_convert_enable) begin
            hw_seq_ff <= 1'b1;
        end
    end

    // ==========================================
    // result bytes, read tracking and done flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_read_ff <= 1'b0;
        end else if (result_low_rd) begin
            hi_read_ff <= 1'b0;
        end else if (result_high_rd) begin
            hi_read_ff <= 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            res_h_ff <= 8'h00;
            res_l_ff <= 8'h00;
        end else if (finish && !blocked && !(compare_enable && !compare_true)) begin
            case (mode_select)
                adc_seq_pkg::MODE_12: begin
                    res_h_ff <= {4'h0, core_result[11:8]};
                    res_l_ff <= core_result[7:0];
                end
                adc_seq_pkg::MODE_10: begin
                    res_h_ff <= {6'h00, core_result[11:10]};
                    res_l_ff <= core_result[9:2];
                end
                default: begin
                    res_h_ff <= 8'h00;
                    res_l_ff <= core_result[11:4];
                end
            endcase
        end
    end
    // set wins over clear; in fifo mode the flag sets on every finish that stores a result, as in single mode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
        end else if (finish && !blocked && !(compare_enable && !compare_true)) begin
            done_ff <= 1'b1;
        end else if (done_flag_clear || status_control_one_wr) begin
            done_ff <= 1'b0;
        end
    end
    // fifo position holds while blocking is active
    assign fifo_advance = finish & fifo_mode & !blocked;
    assign result_high_byte = res_h_ff;
    assign result_low_byte = res_l_ff;
    assign conversion_done_flag = done_ff;
    assign done_irq = done_ff & done_irq_enable;
    assign converter_enable = conv_active & chan_valid;
    assign sample_active = state_ff == adc_seq_pkg::ST_SAMPLE;
    assign async_conv_clock_en = conv_active
        & (input_clock_select == adc_seq_pkg::CLK_ASYNC);

    // ==========================================
    // checks
    sequence s_done_cause;
        $past(finish) ##0 !$past(blocked);
    endsequence
    AST_IDLE_NO_CLK: assert property (@(posedge mclk) disable iff (!rst_n)
        !conv_active |-> !async_conv_clock_en) else $error("async clock on while idle");
    AST_HW_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n)
        (conv_active && hw_trigger_select && trig_rise && !status_control_one_wr
        && !other_ctrl_wr) |-> !hw_start) else $error("edge taken while busy");
    AST_BLOCK: assert property (@(posedge mclk) disable iff (!rst_n)
        (finish && blocked && !done_ff) |=> !done_ff) else $error("done set while blocked");
    AST_DONE_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(done_ff) |-> s_done_cause) else $error("done without completion");
    AST_ABORT: assert property (@(posedge mclk) disable iff (!rst_n)
        other_ctrl_wr |=> !conv_active) else $error("conversion survived abort");
    AST_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
        (other_ctrl_wr && !finish) |=> $stable(res_l_ff)) else $error("abort altered result");
    AST_BLOCK_RELAUNCH: assert property (@(posedge mclk) disable iff (!rst_n)
        (finish && blocked && !compare_enable && !abort_all && chan_valid
        && !status_control_one_wr) |=> sample_active) else $error("no relaunch");
    AST_FIFO_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        blocked |-> !fifo_advance) else $error("fifo moved while blocked");
    AST_INVALID_CH: assert property (@(posedge mclk) disable iff (!rst_n)
        !chan_valid |=> !conv_active) else $error("converter ran on all-ones channel");
    AST_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
        (done_ff && done_irq_enable) |-> done_irq) else $error("irq missing");
endmodule
`default_nettype wire

/* testbench/adc_core_model.sv */
// behavioural analog core and hardware trigger source for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic [11:0] level,
    input wire logic cmp_in,
    input wire logic sample_active,
    input wire logic async_conv_clock_en,
    output wire logic hw_conv_trigger,
    output logic alt_tick,
    output logic async_tick,
    output logic [11:0] core_result,
    output logic compare_true
);
    logic [1:0] alt_cnt_ff;
    logic async_ff;
    logic [11:0] held_ff;
    // pin lags the request by a fraction of a cycle, so it is off the clock grid
    assign #1.3 hw_conv_trigger = fire;
    assign compare_true = cmp_in;
    // mid-sample the answer is not valid yet: show the inverse, never a stale value
    assign core_result = sample_active ? ~held_ff : held_ff;
    assign alt_tick = (alt_cnt_ff == 2'h2);
    assign async_tick = async_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alt_cnt_ff <= 2'h0;
            async_ff <= 1'b0;
            held_ff <= 12'h000;
        end else begin
            alt_cnt_ff <= (alt_cnt_ff == 2'h2) ? 2'h0 : alt_cnt_ff + 2'h1;
            // the oscillator only runs while the sequencer asks for it
            async_ff <= async_conv_clock_en & ~async_ff;
            if (sample_active) begin
                held_ff <= level;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/adc_conversion_sequencer_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module adc_conversion_sequencer_tb;
    logic mclk, rst_n, wr, ien, cont, hws, ow, cmpe, lsmp, ffill, stp, rhr, rlr, dclr;
    logic fire, cmp, aen, cen, samp, fadv, flag, irq, act, trig, altt, asyt, cmpt;
    logic [4:0] ch;
    logic [1:0] mode, ics, div;
    logic [2:0] dep;
    logic [11:0] lvl, res;
    logic [7:0] rh, rl;
    int errors, checks, cyc, n;
    // ==========================================
    // design and far side
    adc_conversion_sequencer #(.STARTUP_CYC(10)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .status_control_one_wr(wr),
        .input_channel_select(ch), .done_irq_enable(ien),
        .continuous_convert_enable(cont), .hw_trigger_select(hws),
        .other_ctrl_wr(ow), .compare_enable(cmpe), .mode_select(mode),
        .long_sample_select(lsmp), .input_clock_select(ics),
        .clock_divide_select(div), .fifo_depth_field(dep), .fifo_filled(ffill),
        .stop_enter(stp), .result_high_rd(rhr), .result_low_rd(rlr),
        .done_flag_clear(dclr), .hw_conv_trigger(trig), .alt_tick(altt),
        .async_tick(asyt), .core_result(res), .compare_true(cmpt),
        .converter_enable(cen), .sample_active(samp), .async_conv_clock_en(aen),
        .fifo_advance(fadv), .result_high_byte(rh), .result_low_byte(rl),
        .conversion_done_flag(flag), .done_irq(irq), .conv_active(act)
    );
    adc_core_model u_core (
        .mclk(mclk), .rst_n(rst_n), .fire(fire), .level(lvl), .cmp_in(cmp),
        .sample_active(samp), .async_conv_clock_en(aen), .hw_conv_trigger(trig),
        .alt_tick(altt), .async_tick(asyt), .core_result(res), .compare_true(cmpt)
    );
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // longest path is the divided timing sweep, some 15600 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    // ==========================================
    // helpers
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask
    task automatic idle(input int k);
        repeat (k) @(negedge mclk);
    endtask
    // n ends as the count of edges from the launching edge to the flag
    task automatic wait_done(input int lim);
        n = 0;
        while (flag !== 1'b1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask
    // conv returns once the flag is up; t_block reads result bytes with the flag down except the high byte read after unblocked, once mid-conversion
    task automatic conv(input logic [11:0] v);
        lvl = v;
        pulse(dclr);
        pulse(wr);
        wait_done(1000);
    endtask
    // ==========================================
    // scenarios
    task automatic t_timing;
        int per, base;
        for (int k = 0; k < 72; k++) begin
            ics = 2'(k / 24);
            div = 2'(k / 6 % 4);
            mode = 2'(k / 2 % 3);
            lsmp = k[0];
            per = (ics == adc_seq_pkg::CLK_ALT ? 3 : int'(ics) + 1) << div;
            base = (mode == adc_seq_pkg::MODE_8 ? 20 : 23) + (lsmp ? 20 : 0);
            conv(12'h5a0 + 12'(k));
            `CHK("done_time", 1'b1, n <= per * (base + 1) + 4)
            `CHK("divided_time", 1'b1, n >= per * 12)
            `CHK("done_irq", 1'b1, irq)
            if (mode == adc_seq_pkg::MODE_12) `CHK("result", {4'h0, lvl}, {rh, rl})
        end
        {ics, div, lsmp} = '0;
        mode = adc_seq_pkg::MODE_12;
    endtask
    task automatic t_off_and_hw;
        ch = adc_seq_pkg::CH_ALL_ONES;
        pulse(dclr);
        pulse(wr);
        idle(40);
        `CHK("off_active", 1'b0, act)
        `CHK("off_enable", 1'b0, cen)
        ch = 5'h03;
        fire = 1'b1;
        idle(40);
        `CHK("hw_unselected", 1'b0, flag)
        fire = 1'b0;
        hws = 1'b1;
        idle(4);
        fire = 1'b1;
        wait_done(100);
        `CHK("hw_start", 1'b1, flag)
        fire = 1'b0;
        pulse(dclr);
        idle(3);
        fire = 1'b1;
        idle(8);
        fire = 1'b0;
        idle(3);
        fire = 1'b1;
        wait_done(100);
        pulse(dclr);
        idle(40);
        `CHK("hw_busy_edge", 1'b0, flag)
        // continuous hw: edges every six cycles would starve a design that restarts
        cont = 1'b1;
        fire = 1'b0;
        idle(4);
        fire = 1'b1;
        wait_done(100);
        pulse(dclr);
        repeat (8) begin
            idle(3);
            fire = ~fire;
        end
        `CHK("hw_cont_edges", 1'b1, flag)
        pulse(dclr);
        wait_done(30);
        `CHK("next_time", 1'b1, n <= 20)
        pulse(ow);
        idle(2);
        pulse(dclr);
        idle(40);
        `CHK("cont_abort", 1'b0, flag | act)
        {cont, hws, fire} = '0;
    endtask
    task automatic t_abort;
        conv(12'h3c5);
        lvl = 12'h0a6;
        pulse(dclr);
        pulse(wr);
        idle(6);
        `CHK("enable_on", 1'b1, cen)
        pulse(ow);
        idle(40);
        `CHK("abort_idle", 1'b0, act)
        `CHK("abort_keep", 16'h03c5, {rh, rl})
        pulse(wr);
        idle(6);
        pulse(stp);
        idle(40);
        `CHK("stop_abort", 1'b0, flag | act)
        ics = adc_seq_pkg::CLK_ASYNC;
        `CHK("async_off", 1'b0, aen)
        pulse(wr);
        idle(4);
        `CHK("async_on", 1'b1, aen)
        pulse(stp);
        wait_done(400);
        `CHK("async_stop_runs", 16'h00a6, {rh, rl})
        idle(4);
        `CHK("async_idle", 1'b0, aen)
        ics = adc_seq_pkg::CLK_BUS;
        pulse(wr);
        idle(5);
        rst_n = 1'b0;
        idle(2);
        `CHK("reset_result", 16'h0000, {rh, rl})
        `CHK("reset_done", 1'b0, flag)
        rst_n = 1'b1;
        idle(30);
        `CHK("reset_idle", 1'b0, act)
    endtask
    task automatic t_block;
        conv(12'h7e1);
        pulse(dclr);
        pulse(rhr);
        lvl = 12'h124;
        pulse(wr);
        idle(80);
        `CHK("blocked_done", 1'b0, flag)
        `CHK("blocked_keep", 16'h07e1, {rh, rl})
        `CHK("blocked_retry", 1'b1, act)
        pulse(rlr);
        wait_done(60);
        `CHK("unblocked", 16'h0124, {rh, rl})
        pulse(rhr);
        cmpe = 1'b1;
        cmp = 1'b0;
        pulse(dclr);
        pulse(wr);
        idle(80);
        `CHK("cmp_stop", 1'b0, act)
        pulse(rlr);
        cmpe = 1'b0;
        cmp = 1'b1;
    endtask
    task automatic t_restart;
        pulse(dclr);
        pulse(wr);
        idle(15);
        pulse(wr);
        wait_done(60);
        `CHK("restart_late", 1'b1, n >= 12)
        `CHK("restart_done", 1'b1, flag)
        dep = 3'h2;
        pulse(wr);
        ffill = 1'b1;
        idle(6);
        `CHK("fifo_start", 1'b1, act)
        ffill = 1'b0;
        pulse(dclr);
        pulse(wr);
        idle(40);
        `CHK("fifo_abort", 1'b0, flag | act)
        ffill = 1'b1;
        idle(6);
        `CHK("fifo_refill", 1'b1, act)
        pulse(ow);
        {ffill, dep} = '0;
        idle(40);
    endtask
    initial begin
        {wr, cont, hws, ow, cmpe, lsmp, ffill, stp, rhr, rlr, dclr, fire} = '0;
        {mode, ics, div, dep} = '0;
        {ien, cmp} = 2'h3;
        ch = 5'h03;
        lvl = 12'h000;
        rst_n = 1'b0;
        idle(8);
        rst_n = 1'b1;
        idle(2);
        t_timing();
        t_off_and_hw();
        t_abort();
        t_block();
        t_restart();
        report_and_stop();
    end
endmodule
`default_nettype wire
